// >>> hdl/ocap_core.sv
// Character attribute, pixel pipeline and output palette with APB access.
// Assumes an APB master on mclk_i; one pixel per clock, 16 per slot.
//
// The register addresses and the APB slave port were decided locally.
`default_nettype none
module ocap_core
	import ocap_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Register bus
	input wire ocap_apb_req_type apb_req_i,
	output ocap_apb_rsp_type apb_rsp_o,
	// Video
	output ocap_video_type video_o,
	output logic slot_start_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic [15:0] cur_pend;
		logic [15:0] nxt_pend;
		logic [15:0] attr_pend;
		logic [15:0] cur;
		logic [15:0] nxt;
		logic [15:0] attr;
		logic [15:0] ctrl;
		logic [15:0] pal;
		logic [2:0] fg_prev;
		logic [31:0] fg_hist;
		logic [31:0] fr_hist;
		logic [15:0] bl_hist;
		logic [2:0] col_hist;
		ocap_apb_rsp_type rsp;
		ocap_video_type vid;
		logic slot_start;
	} ocap_state_type;

	ocap_state_type s_q;
	ocap_state_type s_d;

	function automatic logic [1:0] ocap_mix(input logic p,
		input logic o0, input logic o1, input logic [1:0] m);
		logic [2:0] sum;
		sum = (p ? 3'h2 : 3'h0) + {2'h0, m[0] & o0} + {2'h0, m[1] & o1};
		ocap_mix = (sum > 3'h3) ? LVL_FULL : sum[1:0];
	endfunction : ocap_mix

	logic wr_acc;
	logic rd_acc;
	logic latch;
	logic [3:0] idx;
	logic [3:0] pos;
	logic [7:0] x3;
	logic cur_bit;
	logic left_bit;
	logic right_bit;
	logic nb_bit;
	logic smooth;
	logic under;
	logic pal_mode;
	logic hide;
	logic fg_pix;
	logic fr_pix;
	logic [4:0] dly;
	logic d_fg;
	logic d_fr;
	logic [2:0] fg_col;
	logic [2:0] col_now;
	logic [3:0] cdly;
	logic [2:0] col;
	logic on;
	logic wr_done;
	logic [1:0] lvl_tab [3][8];
	logic [31:0] rdata;
	logic hit;

	// Palette stage as a level table per channel and colour, from the palette
	// register only; channel 2 is a (red), 1 is b (green), 0 is c (blue)
	for (genvar k = 0; k < 3; k++) begin : g_chan
		for (genvar c = 0; c < 8; c++) begin : g_col
			localparam logic [2:0] CV = 3'(c);
			localparam int OTH0 = (k == 0) ? 1 : 0;
			localparam int OTH1 = (k == 2) ? 1 : 2;
			assign lvl_tab[k][c] = (s_q.pal[PAL_CHAN_C +: 6] == 6'h00) ?
				(CV[k] ? LVL_FULL : 2'h0) :
				s_q.pal[PAL_FIXED] ? FIXED_TABLE[6 * c + 2 * k +: 2] :
				ocap_mix(CV[k], CV[OTH0], CV[OTH1],
				s_q.pal[PAL_CHAN_C + 2 * k +: 2]);
		end
	end

	always_comb begin
		s_d = s_q;
		wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite &
			~s_q.rsp.pready;
		rd_acc = apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite &
			~s_q.rsp.pready;
		wr_done = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite &
			s_q.rsp.pready;
		// Register bus: one wait state, answer registered; a write lands at
		// the edge where the master sees ready
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (apb_req_i.paddr)
			ADDR_CUR_ROW: rdata = 32'h0000_0000;
			ADDR_NXT_ROW: rdata = 32'h0000_0000;
			ADDR_CHAR_ATTRIBUTE: rdata = 32'h0000_0000;
			ADDR_DISPLAY_CONTROL: rdata = {16'h0000, s_q.ctrl};
			ADDR_SLOT_STATUS: rdata = {24'h0, s_q.vid.blank, s_q.col_hist,
				s_q.cnt};
			ADDR_OUTPUT_PALETTE_CONTROL: rdata = {16'h0000, s_q.pal};
			default: hit = 1'b0;
		endcase
		s_d.rsp.pready = wr_acc | rd_acc;
		s_d.rsp.pslverr = (wr_acc | rd_acc) & ~hit;
		s_d.rsp.prdata = rd_acc ? rdata : 32'h0000_0000;
		if (wr_done) begin
			case (apb_req_i.paddr)
				ADDR_CUR_ROW: s_d.cur_pend = apb_req_i.pwdata[15:0];
				ADDR_NXT_ROW: s_d.nxt_pend = apb_req_i.pwdata[15:0];
				ADDR_CHAR_ATTRIBUTE: s_d.attr_pend = apb_req_i.pwdata[15:0];
				ADDR_DISPLAY_CONTROL: s_d.ctrl = apb_req_i.pwdata[15:0];
				ADDR_OUTPUT_PALETTE_CONTROL: s_d.pal =
					apb_req_i.pwdata[15:0] & PAL_KEEP;
				default: s_d.pal = s_q.pal;
			endcase
		end
		// Slot timing; latch pending set and clear it for the next slot
		s_d.cnt = s_q.cnt + 4'h1;
		latch = (s_q.cnt == SLOT_LAST);
		s_d.slot_start = latch;
		if (latch) begin
			s_d.cur = s_d.cur_pend;
			s_d.nxt = s_d.nxt_pend;
			s_d.attr = s_d.attr_pend;
			s_d.cur_pend = 16'h0000;
			s_d.nxt_pend = 16'h0000;
			s_d.attr_pend = 16'h0000;
		end
		// Pixel index per glyph size; reserved size shows normal
		x3 = {4'h0, s_q.cnt} * 8'h0b;
		case (s_q.ctrl[CTL_SIZE +: 2])
			SIZE_X2: idx = {1'b0, s_q.cnt[3:1]};
			SIZE_X3: idx = {1'b0, x3[7:5]};
			default: idx = s_q.cnt;
		endcase
		pos = 4'hf - idx;
		cur_bit = s_q.cur[pos];
		left_bit = (pos != 4'hf) ? s_q.cur[pos + 4'h1] : 1'b0;
		right_bit = (pos != 4'h0) ? s_q.cur[pos - 4'h1] : 1'b0;
		nb_bit = s_q.nxt[pos];
		smooth = s_q.attr[ATR_SMOOTH] & ~cur_bit & nb_bit &
			(left_bit | right_bit);
		// Palette mode follows the caption setting of the control register
		pal_mode = ~s_q.ctrl[CTL_OVERLAY];
		under = (s_q.attr[ATR_UL1] & s_q.ctrl[CTL_UL1]) |
			(pal_mode & s_q.attr[ATR_UL2] & s_q.ctrl[CTL_UL2]);
		hide = s_q.attr[ATR_BLINK] & ~s_q.ctrl[CTL_BLINK_VIS];
		fg_pix = ~hide & (cur_bit | smooth | under);
		fr_pix = ~hide & s_q.attr[ATR_FRINGE] & ~fg_pix &
			(left_bit | right_bit | nb_bit);
		s_d.fg_hist = {s_q.fg_hist[30:0], fg_pix};
		s_d.fr_hist = {s_q.fr_hist[30:0], fr_pix};
		dly = (s_q.attr[ATR_SHIFT] ? SHIFT_PIXELS : 5'h00) +
			(s_q.attr[ATR_ITALIC] ?
			{1'b0, s_q.ctrl[CTL_ITAL +: 4]} : 5'h00);
		d_fg = s_d.fg_hist[dly];
		d_fr = s_d.fr_hist[dly];
		// Foreground colour with lagged change
		fg_col = pal_mode ? {s_q.attr[ATR_PSEL +: 2], 1'b1} :
			s_q.attr[ATR_FG +: 3];
		cdly = {s_q.attr[ATR_CDLY +: 2], 2'b00};
		col_now = (s_q.cnt < cdly) ? s_q.fg_prev : fg_col;
		if (latch) begin
			s_d.fg_prev = fg_col;
		end
		if (d_fg) begin
			col = col_now;
			on = 1'b1;
		end else if (d_fr) begin
			col = COLOR_BLACK;
			on = 1'b1;
		end else if (~s_q.attr[ATR_TRANSP]) begin
			col = s_q.attr[ATR_BG +: 3];
			on = 1'b1;
		end else if (s_q.pal[PAL_BG_ON]) begin
			col = s_q.pal[PAL_BG +: 3];
			on = 1'b1;
		end else begin
			col = COLOR_BLACK;
			on = 1'b0;
		end
		s_d.col_hist = col;
		// Blank line delayed by the lag field
		s_d.bl_hist = {s_q.bl_hist[14:0], on};
		s_d.vid.blank = s_d.bl_hist[s_q.pal[PAL_HBLANK_LAG +: 4]];
		// Palette stage: colour bit 2 red, 1 green, 0 blue
		s_d.vid.video_out_a = lvl_tab[2][col];
		s_d.vid.video_out_b = lvl_tab[1][col];
		s_d.vid.video_out_c = lvl_tab[0][col];
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.ctrl <= DISPLAY_CONTROL_RST;
			s_q.pal <= OUTPUT_PALETTE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp_o = s_q.rsp;
	assign video_o = s_q.vid;
	assign slot_start_o = s_q.slot_start;
endmodule : ocap_core
`default_nettype wire

// >>> hdl/ocap_pkg.sv
// Constants and carriers for the character attribute and palette block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
`default_nettype none
package ocap_pkg;
	// Register byte addresses
	localparam logic [11:0] ADDR_CUR_ROW = 12'h000;
	localparam logic [11:0] ADDR_NXT_ROW = 12'h004;
	localparam logic [11:0] ADDR_CHAR_ATTRIBUTE = 12'h008;
	localparam logic [11:0] ADDR_DISPLAY_CONTROL = 12'h010;
	localparam logic [11:0] ADDR_SLOT_STATUS = 12'h014;
	localparam logic [11:0] ADDR_OUTPUT_PALETTE_CONTROL = 12'h01c;
	// Reset values
	localparam logic [15:0] DISPLAY_CONTROL_RST = 16'h0000;
	localparam logic [15:0] OUTPUT_PALETTE_RST = 16'h0000;
	// Character attribute fields
	localparam int ATR_BG = 12;
	localparam int ATR_FG = 9;
	localparam int ATR_PSEL = 10;
	localparam int ATR_UL2 = 9;
	localparam int ATR_UL1 = 8;
	localparam int ATR_SHIFT = 7;
	localparam int ATR_TRANSP = 6;
	localparam int ATR_BLINK = 5;
	localparam int ATR_ITALIC = 4;
	localparam int ATR_CDLY = 2;
	localparam int ATR_FRINGE = 1;
	localparam int ATR_SMOOTH = 0;
	// Display control fields
	localparam int CTL_UL2 = 15;
	localparam int CTL_UL1 = 14;
	localparam int CTL_OVERLAY = 13;
	localparam int CTL_BLINK_VIS = 12;
	localparam int CTL_ITAL = 8;
	localparam int CTL_SIZE = 5;
	localparam int CTL_SCAN = 0;
	// Output palette control fields
	localparam int PAL_HBLANK_LAG = 12;
	localparam int PAL_BG_ON = 11;
	localparam int PAL_BG = 8;
	localparam int PAL_FIXED = 6;
	localparam int PAL_CHAN_A = 4;
	localparam int PAL_CHAN_B = 2;
	localparam int PAL_CHAN_C = 0;
	// Bit 7 is reserved: never stored, reads 0
	localparam logic [15:0] PAL_KEEP = 16'hff7f;
	// Glyph sizes
	localparam logic [1:0] SIZE_X1 = 2'h0;
	localparam logic [1:0] SIZE_X2 = 2'h1;
	localparam logic [1:0] SIZE_X3 = 2'h2;
	// Timing in pixels (one pixel per clock)
	localparam logic [3:0] SLOT_LAST = 4'hf;
	localparam logic [4:0] SHIFT_PIXELS = 5'h08;
	// Output levels: 0, 33, 66, 100 percent
	localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
	localparam logic [1:0] LVL_FULL = 2'h3;
	// Fixed table, entry i at bits 6i+5..6i as {a, b, c}
	localparam logic [47:0] FIXED_TABLE = {6'h3f, 6'h3c, 6'h3c, 6'h35,
		6'h2a, 6'h2f, 6'h0f, 6'h00};
	localparam logic [2:0] COLOR_BLACK = 3'h0;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ocap_apb_req_type;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} ocap_apb_rsp_type;

	typedef struct packed {
		logic [1:0] video_out_a;
		logic [1:0] video_out_b;
		logic [1:0] video_out_c;
		logic blank;
	} ocap_video_type;
endpackage : ocap_pkg
`default_nettype wire

// >>> tb/ocap_assertions.sv
// Port checker for the attribute and palette block.
// Assumes the core's single clock and synchronous reset.
`default_nettype none
module ocap_assertions
	import ocap_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire ocap_apb_req_type apb_req_i,
	input wire ocap_apb_rsp_type apb_rsp_o,
	input wire ocap_video_type video_o,
	input wire logic slot_start_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	property p_slot_gap;
		slot_start_o |=> !slot_start_o [*8] ##1 !slot_start_o [*7]
			##1 slot_start_o;
	endproperty
	a_slot_gap: assert property (p_slot_gap)
		else $error("slot spacing wrong");
	property p_rdy_take;
		apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready
			|=> apb_rsp_o.pready;
	endproperty
	a_rdy_take: assert property (p_rdy_take)
		else $error("no answer to access");
	property p_rdy_once;
		apb_rsp_o.pready |=> !apb_rsp_o.pready;
	endproperty
	a_rdy_once: assert property (p_rdy_once)
		else $error("ready held too long");
	property p_rdy_cause;
		apb_rsp_o.pready |-> $past(apb_req_i.psel && apb_req_i.penable);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause)
		else $error("ready without access");
	property p_err_rdy;
		apb_rsp_o.pslverr |-> apb_rsp_o.pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy)
		else $error("error without ready");
	property p_idle_data;
		!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0;
	endproperty
	a_idle_data: assert property (p_idle_data)
		else $error("read data outside answer");
	property p_hi_zero;
		apb_rsp_o.pready |-> apb_rsp_o.prdata[31:16] == 16'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("upper read bits set");
	property p_rst_out;
		$fell(sys_rst_i) |-> video_o == '0 && !slot_start_o;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not clear after reset");
endmodule : ocap_assertions
bind ocap_core ocap_assertions u_chk (.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
	.video_o(video_o), .slot_start_o(slot_start_o));
`default_nettype wire

// >>> tb/ocap_tv_mux.sv
// Video multiplexer model: overlay replaces picture where blank is high.
// Assumes the core's registered video outputs on the same clock.
`default_nettype none
module ocap_tv_mux
	import ocap_pkg::*;
(
	input wire logic mclk_i,
	input wire ocap_video_type video_i,
	output logic [5:0] mix_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk_i) begin
		mix_o <= video_i.blank ? {video_i.video_out_a, video_i.video_out_b,
			video_i.video_out_c} : 6'h00;
	end
endmodule : ocap_tv_mux
`default_nettype wire

// >>> tb/test_osd_char_attribute_palette.sv
// Self-checking bench: APB master, random attributes, video compare.
// Assumes ocap_core and the multiplexer model on a 100 MHz clock.
`default_nettype none
module test_osd_char_attribute_palette
	import ocap_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ocap_apb_req_type req = '0;
	ocap_apb_rsp_type rsp;
	ocap_video_type vid;
	logic ss;
	logic [5:0] mix;
	int num_errors = 0;
	int checks_done = 0;
	ocap_core dut (.mclk_i(clk), .sys_rst_i(rst), .apb_req_i(req),
		.apb_rsp_o(rsp), .video_o(vid), .slot_start_o(ss));
	ocap_tv_mux tv (.mclk_i(clk), .video_i(vid), .mix_o(mix));
	initial begin
		forever #5 clk = ~clk;
	end
	task results;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// No release at the end: back-to-back calls go straight to setup
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, 32'(rsp.pready));
		r = rsp.prdata;
		e = rsp.pslverr;
	endtask : xfer
	task wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, {16'($urandom), d}, r, e);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0, r, e);
		chk("prdata", x, r);
		chk("pslverr", 32'(xe), 32'(e));
	endtask : rd
	task slot;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ss !== 1'b1 && n < 40);
	endtask : slot
	task vchk(input logic [6:0] x);
		@(posedge clk);
		if (x[0])
			chk("video", 32'(x), 32'(vid));
		else
			chk("blank", 32'h0, 32'(vid.blank));
	endtask : vchk
	function automatic logic [6:0] px(input logic [2:0] c);
		return {{2{c[2]}}, {2{c[1]}}, {2{c[0]}}, 1'b1};
	endfunction : px
	// Levels in thirds: primary 66 percent, each mixed other 33 percent
	function automatic logic [6:0] pv(input logic [2:0] c,
		input logic [6:0] p);
		logic [2:0] n;
		logic [6:0] v;
		v = 7'h01;
		for (int k = 0; k < 3; k++) begin
			if (p[5:0] == 6'h00)
				n = c[k] ? 3'h3 : 3'h0;
			else if (p[6])
				n = {1'b0, FIXED_TABLE[6 * c + 2 * k +: 2]};
			else
				n = {1'b0, c[k], 1'b0} + {2'h0, p[2 * k] & c[k == 0 ? 1 : 0]} +
					{2'h0, p[2 * k + 1] & c[k == 2 ? 1 : 2]};
			v[2 * k + 1 +: 2] = (n > 3'h3) ? 2'h3 : n[1:0];
		end
		return v;
	endfunction : pv
	initial begin
		logic [31:0] s;
		logic [2:0] bg;
		logic t, bl, vi;
		logic [6:0] e;
		s = $urandom(34);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ADDR_DISPLAY_CONTROL, 32'h0, 1'b0);
		rd(ADDR_OUTPUT_PALETTE_CONTROL, 32'h0, 1'b0);
		rd(ADDR_CHAR_ATTRIBUTE, 32'h0, 1'b0);
		rd(12'h0f0, 32'h0, 1'b1);
		s = $urandom;
		wr(ADDR_OUTPUT_PALETTE_CONTROL, s[15:0]);
		rd(ADDR_OUTPUT_PALETTE_CONTROL, 32'(s[15:0] & 16'hff7f), 1'b0);
		s = $urandom & 32'hffbf;
		wr(ADDR_DISPLAY_CONTROL, s[15:0]);
		rd(ADDR_DISPLAY_CONTROL, 32'(s[15:0]), 1'b0);
		wr(ADDR_OUTPUT_PALETTE_CONTROL, 16'h0);
		req <= '0;
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			bg = 3'($urandom);
			{t, bl, vi} = 3'($urandom);
			slot();
			wr(ADDR_DISPLAY_CONTROL, {3'h1, vi, 12'h0});
			wr(ADDR_CHAR_ATTRIBUTE, {1'b0, bg, 3'(i), 2'h0, t, bl, 5'h0});
			wr(ADDR_CUR_ROW, 16'h8000);
			req <= '0;
			slot();
			e = (bl && !vi) ? (t ? 7'h0 : px(bg)) : px(3'(i));
			vchk(e);
			vchk(t ? 7'h0 : px(bg));
			chk("mix", 32'(e[0] ? e[6:1] : 6'h00), 32'(mix));
		end
		$display("colour test done");
		for (int i = 0; i < 8; i++) begin
			bg = 3'($urandom);
			s = $urandom;
			slot();
			wr(ADDR_DISPLAY_CONTROL, 16'h1000);
			wr(ADDR_OUTPUT_PALETTE_CONTROL, {9'h0, s[6:0]});
			wr(ADDR_CHAR_ATTRIBUTE, {1'b0, bg, s[9:8], 10'h0});
			wr(ADDR_CUR_ROW, 16'h8000);
			req <= '0;
			slot();
			vchk(pv({s[9:8], 1'b1}, s[6:0]));
			vchk(pv(bg, s[6:0]));
		end
		$display("palette test done");
		slot();
		wr(ADDR_CUR_ROW, 16'h0);
		req <= '0;
		slot();
		@(posedge clk);
		vchk(px(3'h0));
		$display("space test done");
		results();
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule : test_osd_char_attribute_palette
`default_nettype wire
